// ==== include/dcr_pkg.sv ====
// Shared constants and carriers for the converter configuration register bank.
// Assumes a single 100 MHz core clock and a serial port host that sends MSB first.
package dcr_pkg;

  // Register offsets on the serial port.
  localparam logic [6:0] DCR_ADDR_TXGATE = 7'h02;
  localparam logic [6:0] DCR_ADDR_FORMAT = 7'h03;
  localparam logic [6:0] DCR_ADDR_IRQEN = 7'h04;
  localparam logic [6:0] DCR_ADDR_FLAGS = 7'h06;

  // Field positions in the transmit gate power control register.
  localparam int DCR_TXG_REF = 4;
  localparam int DCR_TXG_PLL = 3;
  localparam int DCR_TXG_DAC = 2;
  localparam int DCR_TXG_FIFO = 1;
  localparam int DCR_TXG_FILT = 0;

  // Field positions in the input data format register.
  localparam int DCR_FMT_BINARY = 7;
  localparam int DCR_FMT_QFIRST = 6;
  localparam int DCR_FMT_SWAP = 5;
  localparam int DCR_FMT_WIDTH_HI = 1;
  localparam int DCR_FMT_WIDTH_LO = 0;

  // Event positions, shared by the enable and flag registers.
  localparam int DCR_EV_PLL_LOST = 7;
  localparam int DCR_EV_PLL_LOCK = 6;
  localparam int DCR_EV_SYNC_LOST = 5;
  localparam int DCR_EV_SYNC_LOCK = 4;

  // Writable masks and reset values.
  localparam logic [7:0] DCR_TXG_MASK = 8'h1F;
  localparam logic [7:0] DCR_FMT_MASK = 8'hE3;
  localparam logic [7:0] DCR_EV_MASK = 8'hF0;
  localparam logic [7:0] DCR_RESET_VAL = 8'h00;

  // Bus width codes.
  localparam logic [1:0] DCR_WIDTH_NIBBLE = 2'h2;
  localparam logic [1:0] DCR_WIDTH_INVALID = 2'h3;

  // Serial frame: one instruction byte then one data byte.
  localparam logic [4:0] DCR_INSTR_BITS = 5'h08;
  localparam logic [4:0] DCR_FRAME_BITS = 5'h10;

  typedef struct packed {
    logic ref_pd;
    logic pll_pd;
    logic dac_pd;
    logic fifo_pd;
    logic filter_pd;
  } dcr_power_t;

  typedef struct packed {
    logic straight_binary;
    logic q_first;
    logic bit_swap;
    logic byte_mode;
    logic nibble_mode;
    logic width_invalid;
  } dcr_format_t;

endpackage : dcr_pkg

// ==== hw/dcr_bank.sv ====
// Configuration register bank with a three-wire serial port slave.
// Assumes serial pins and analog lock levels arrive asynchronously and are resynchronised here.
`timescale 1ns/1ps
module dcr_bank
  import dcr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic transmit_gate_pin,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  input wire logic pll_lock_in,
  input wire logic sync_lock_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_ordered,
  output dcr_power_t power_down,
  output dcr_format_t format,
  output logic irq
);

  typedef enum logic [3:0] {
    DCR_ST_IDLE = 4'b0001,
    DCR_ST_INSTR = 4'b0010,
    DCR_ST_DATA = 4'b0100,
    DCR_ST_DONE = 4'b1000
  } dcr_state_t;

  // Bit reversal, used for the data port and kept as a function for reuse.
  function automatic logic [15:0] dcr_reverse(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction : dcr_reverse

  // The gate, serial and lock pins pass two flops before any logic reads them; edges of the serial clock and
  // of the lock levels are found one flop later, so no logic ever reads a metastable stage.
  localparam int DCR_ASYNC_N = 6;
  wire [DCR_ASYNC_N-1:0] async_raw = {transmit_gate_pin, spi_cs_n, sdio_in, spi_sclk, pll_lock_in, sync_lock_in};
  wire [DCR_ASYNC_N-1:0] async_sync;

  for (genvar g = 0; g < DCR_ASYNC_N; g++)
  begin : g_sync
    logic [1:0] stage_q;

    always_ff @(posedge clock)
    begin
      stage_q <= {stage_q[0], async_raw[g]};
    end

    assign async_sync[g] = stage_q[1];
  end

  wire gate_sync = async_sync[5];
  wire cs_sync = async_sync[4];
  wire sdi = async_sync[3];
  wire sclk_sync = async_sync[2];
  wire pll_lvl = async_sync[1];
  wire sync_lvl = async_sync[0];

  logic sclk_last_q;
  logic pll_prev_q;
  logic sync_prev_q;

  always_ff @(posedge clock)
  begin
    sclk_last_q <= sclk_sync;
    pll_prev_q <= pll_lvl;
    sync_prev_q <= sync_lvl;
  end

  wire gate_low = ~gate_sync;
  wire cs_active = ~cs_sync;
  wire sclk_rise = sclk_sync & ~sclk_last_q;
  wire sclk_fall = ~sclk_sync & sclk_last_q;

  // Serial frame state.
  dcr_state_t state_q;
  dcr_state_t state_d;
  logic [4:0] count_q;
  logic [7:0] shift_q;
  logic [7:0] instr_q;
  logic [7:0] rd_shift_q;
  logic sdio_out_q;
  logic drive_q;

  wire instr_done = sclk_rise & (count_q == DCR_INSTR_BITS - 5'h01);
  wire data_done = sclk_rise & (count_q == DCR_FRAME_BITS - 5'h01);
  wire [7:0] instr_full = {shift_q[6:0], sdi};
  wire [7:0] wr_data = {shift_q[6:0], sdi};
  wire is_read = instr_q[7];
  wire [6:0] frame_addr = instr_q[6:0];
  wire wr_strobe = (state_q == DCR_ST_DATA) & data_done & ~is_read;
  wire instr_capture = instr_done & (state_q == DCR_ST_INSTR);
  wire rd_step = cs_active & sclk_fall & (state_q == DCR_ST_DATA) & is_read;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DCR_ST_IDLE:
        if (cs_active)
          state_d = DCR_ST_INSTR;
      DCR_ST_INSTR:
        if (!cs_active)
          state_d = DCR_ST_IDLE;
        else if (instr_done)
          state_d = DCR_ST_DATA;
      DCR_ST_DATA:
        if (!cs_active)
          state_d = DCR_ST_IDLE;
        else if (data_done)
          state_d = DCR_ST_DONE;
      DCR_ST_DONE:
        if (!cs_active)
          state_d = DCR_ST_IDLE;
      default:
        state_d = DCR_ST_IDLE;
    endcase
  end

  // Registers.
  logic [7:0] txg_q;
  logic [7:0] fmt_q;
  logic [7:0] ien_q;
  logic [7:0] flags_q;

  wire wr_txg = wr_strobe & (frame_addr == DCR_ADDR_TXGATE);
  wire wr_fmt = wr_strobe & (frame_addr == DCR_ADDR_FORMAT);
  wire wr_ien = wr_strobe & (frame_addr == DCR_ADDR_IRQEN);
  wire wr_flags = wr_strobe & (frame_addr == DCR_ADDR_FLAGS);

  // Read mux; unmapped addresses return zero.
  wire [6:0] rd_addr = instr_full[6:0];
  wire [7:0] rd_value = (rd_addr == DCR_ADDR_TXGATE) ? txg_q :
                        (rd_addr == DCR_ADDR_FORMAT) ? fmt_q :
                        (rd_addr == DCR_ADDR_IRQEN) ? ien_q :
                        (rd_addr == DCR_ADDR_FLAGS) ? flags_q : 8'h00;

  // Bit counter and shift register; a deselect discards a partial frame without a write.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= DCR_ST_IDLE;
      count_q <= 5'h00;
      shift_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (!cs_active)
      begin
        count_q <= 5'h00;
      end
      else if (sclk_rise && (state_q != DCR_ST_DONE))
      begin
        count_q <= count_q + 5'h01;
        shift_q <= {shift_q[6:0], sdi};
      end
    end
  end

  // The instruction byte is kept through the data phase, since direction and address decode from it.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      instr_q <= 8'h00;
    end
    else if (instr_capture)
    begin
      instr_q <= instr_full;
    end
  end

  // Readback bits change on the falling serial clock so the host samples them stable.
  // The byte is taken when the instruction completes, so a flag set mid-frame cannot tear it.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rd_shift_q <= 8'h00;
      sdio_out_q <= 1'b0;
    end
    else if (instr_capture)
    begin
      rd_shift_q <= rd_value;
    end
    else if (rd_step)
    begin
      sdio_out_q <= rd_shift_q[7];
      rd_shift_q <= {rd_shift_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      drive_q <= 1'b0;
    end
    else if (rd_step)
    begin
      drive_q <= 1'b1;
    end
    else if (!cs_active || (state_q == DCR_ST_DONE && sclk_fall))
    begin
      drive_q <= 1'b0;
    end
  end

  assign sdio_out = sdio_out_q;
  assign sdio_oe_n = ~drive_q;

  // Event detection on synchronised lock levels.
  wire pll_lost_ev = pll_prev_q & ~pll_lvl;
  wire pll_lock_ev = ~pll_prev_q & pll_lvl;
  wire sync_lost_ev = sync_prev_q & ~sync_lvl;
  wire sync_lock_ev = ~sync_prev_q & sync_lvl;
  wire [7:0] ev_set = {pll_lost_ev, pll_lock_ev, sync_lost_ev, sync_lock_ev, 4'h0};
  wire [7:0] ev_clr = wr_flags ? (wr_data & DCR_EV_MASK) : 8'h00;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      txg_q <= DCR_RESET_VAL;
      fmt_q <= DCR_RESET_VAL;
      ien_q <= DCR_RESET_VAL;
      flags_q <= DCR_RESET_VAL;
    end
    else
    begin
      if (wr_txg)
        txg_q <= wr_data & DCR_TXG_MASK;
      if (wr_fmt)
        fmt_q <= wr_data & DCR_FMT_MASK;
      if (wr_ien)
        ien_q <= wr_data & DCR_EV_MASK;
      // A new event in the cycle of its clear stays set.
      flags_q <= ((flags_q & ~ev_clr) | ev_set) & DCR_EV_MASK;
    end
  end

  // Power-down outputs follow the gate pin once the enable bits are set; the pin is not latched,
  // so raising it ends every power-down without a register write.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      power_down <= '0;
    end
    else
    begin
      power_down.ref_pd <= txg_q[DCR_TXG_REF] & gate_low;
      power_down.pll_pd <= txg_q[DCR_TXG_PLL] & gate_low;
      power_down.dac_pd <= txg_q[DCR_TXG_DAC] & gate_low;
      power_down.fifo_pd <= txg_q[DCR_TXG_FIFO] & gate_low;
      power_down.filter_pd <= txg_q[DCR_TXG_FILT] & gate_low;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      format <= '0;
    end
    else
    begin
      format.straight_binary <= fmt_q[DCR_FMT_BINARY];
      format.q_first <= fmt_q[DCR_FMT_QFIRST];
      format.bit_swap <= fmt_q[DCR_FMT_SWAP];
      format.byte_mode <= ~fmt_q[DCR_FMT_WIDTH_HI];
      format.nibble_mode <= fmt_q[DCR_FMT_WIDTH_HI:DCR_FMT_WIDTH_LO] == DCR_WIDTH_NIBBLE;
      format.width_invalid <= fmt_q[DCR_FMT_WIDTH_HI:DCR_FMT_WIDTH_LO] == DCR_WIDTH_INVALID;
    end
  end

  // The swapped word is registered, so the data port lags its input by one cycle.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      data_ordered <= 16'h0000;
      irq <= 1'b0;
    end
    else
    begin
      data_ordered <= fmt_q[DCR_FMT_SWAP] ? dcr_reverse(data_in) : data_in;
      irq <= |(flags_q & ien_q);
    end
  end

endmodule : dcr_bank

// ==== sim/dcr_bank_assertions.sv ====
// Port-level checker for the configuration register bank.
// Assumes one core clock and the synchronous active-high reset.
`timescale 1ns/1ps
module dcr_bank_assertions
  import dcr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic transmit_gate_pin,
  input wire logic spi_cs_n,
  input wire logic sdio_oe_n,
  input wire logic pll_lock_in,
  input wire logic sync_lock_in,
  input wire logic [15:0] data_in,
  input wire logic [15:0] data_ordered,
  input wire dcr_power_t power_down,
  input wire dcr_format_t format,
  input wire logic irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_pd_gate_open: assert property (transmit_gate_pin [*5] |-> power_down == '0)
    else $error("power down while gate open");
  a_pd_needs_gate: assert property (power_down != '0 |->
    !$past(transmit_gate_pin, 2) || !$past(transmit_gate_pin, 3) || !$past(transmit_gate_pin, 4))
    else $error("power down without gate low");
  // Swap must hold two cycles so a one-cycle lag of the format port is tolerated.
  a_swap_path: assert property (!$past(rst) && $stable(format.bit_swap) && $past(format.bit_swap, 2) == format.bit_swap
    |-> data_ordered == (format.bit_swap ? 16'({<<{$past(data_in)}}) : $past(data_in)))
    else $error("data order path wrong");
  a_width_onehot: assert property (!$past(rst) && !$past(rst, 2) |->
    $onehot({format.byte_mode, format.nibble_mode, format.width_invalid}))
    else $error("width decode not one-hot");
  a_irq_quiet: assert property ((!irq && spi_cs_n && $stable(pll_lock_in) && $stable(sync_lock_in)) [*8] |=> !irq)
    else $error("interrupt without cause");
  a_irq_holds: assert property (irq && spi_cs_n && $past(spi_cs_n, 4) |=> irq)
    else $error("interrupt dropped without clear");
  a_oe_idle: assert property (spi_cs_n [*6] |-> sdio_oe_n)
    else $error("readback driven while deselected");
  a_reset_clear: assert property ($past(rst) |-> power_down == '0 && !irq && format[5:3] == 3'h0 && sdio_oe_n)
    else $error("reset left a field set");
endmodule : dcr_bank_assertions
bind dcr_bank dcr_bank_assertions dcr_bank_assertions_inst (.clock(clock), .rst(rst),
  .transmit_gate_pin(transmit_gate_pin), .spi_cs_n(spi_cs_n), .sdio_oe_n(sdio_oe_n), .pll_lock_in(pll_lock_in),
  .sync_lock_in(sync_lock_in), .data_in(data_in), .data_ordered(data_ordered), .power_down(power_down),
  .format(format), .irq(irq));

// ==== sim/dcr_host.sv ====
// Serial port host model issuing one instruction byte and one data byte per frame.
// Assumes five core clocks per serial half period, slow enough for the bank's synchronisers.
`timescale 1ns/1ps
module dcr_host
(
  input wire logic clock,
  input wire logic sdio_line,
  output logic spi_sclk = 1'b0,
  output logic spi_cs_n = 1'b1,
  output logic host_bit = 1'b0
);
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] r);
    logic [15:0] frame;
    frame = {rd, a, d};
    r = 8'h00;
    spi_cs_n <= 1'b0;
    repeat (5) @(posedge clock);
    for (int i = 15; i >= 0; i--)
    begin
      spi_sclk <= 1'b0;
      // During readback the host lets the line float high, so only the bank can pull a bit low.
      host_bit <= (rd && i < 8) ? 1'b1 : frame[i];
      repeat (5) @(posedge clock);
      spi_sclk <= 1'b1;
      if (i < 8) r[i] = sdio_line;
      repeat (5) @(posedge clock);
    end
    spi_sclk <= 1'b0;
    repeat (5) @(posedge clock);
    spi_cs_n <= 1'b1;
    // Released data line flips so a stale bit is never mistaken for a driven one.
    host_bit <= ~host_bit;
    repeat (5) @(posedge clock);
  endtask : xfer
endmodule : dcr_host

// ==== sim/testbench.sv ====
// Self-checking bench for the register bank driven through the serial host model.
// Assumes the host model paces frames and the checker is bound separately.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench
  import dcr_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic transmit_gate_pin = 1'b1;
  logic pll_lock_in = 1'b0;
  logic sync_lock_in = 1'b0;
  logic [15:0] data_in = 16'h1234;
  logic [15:0] data_ordered, sw;
  logic spi_sclk, spi_cs_n, host_bit, sdio_out, sdio_oe_n, irq;
  logic [7:0] v;
  dcr_power_t power_down;
  dcr_format_t format;
  int errors = 0;
  int n_compared = 0;
  wire sdio_in = sdio_oe_n ? host_bit : sdio_out;
  dcr_bank dcr_bank_inst (.clock(clock), .rst(rst), .transmit_gate_pin(transmit_gate_pin), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .pll_lock_in(pll_lock_in),
    .sync_lock_in(sync_lock_in), .data_in(data_in), .data_ordered(data_ordered), .power_down(power_down),
    .format(format), .irq(irq));
  dcr_host dcr_host_inst (.clock(clock), .sdio_line(sdio_in), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .host_bit(host_bit));
  initial
  begin
    forever #5 clock = ~clock;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    dcr_host_inst.xfer(1'b0, a, d, r);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    dcr_host_inst.xfer(1'b1, a, 8'h00, r);
    `CHK("readback", e, r)
  endtask : rd
  task automatic wait_irq(input logic e);
    for (int k = 0; k < 20 && irq !== e; k++) @(posedge clock);
    `CHK("irq", e, irq)
  endtask : wait_irq
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial
  begin
    #200000;
    errors++;
    print_verdict();
  end
  initial
  begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    for (int a = 2; a < 5; a++) rd(7'(a), 8'h00);
    `CHK("byte_mode", 1'b1, format.byte_mode)
    transmit_gate_pin <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      v = (i < 5) ? 8'h01 << i : 8'hFF;
      wr(DCR_ADDR_TXGATE, v);
      repeat (6) @(posedge clock);
      `CHK("power_down", v[4:0], power_down)
    end
    rd(DCR_ADDR_TXGATE, DCR_TXG_MASK);
    transmit_gate_pin <= 1'b1;
    repeat (6) @(posedge clock);
    `CHK("power_down", 5'h00, power_down)
    sw = {<<{data_in}};
    for (int c = 0; c < 4; c++)
    begin
      v = {c[0], c[1], c[0], 3'h7, c[1:0]};
      wr(DCR_ADDR_FORMAT, v);
      rd(DCR_ADDR_FORMAT, v & DCR_FMT_MASK);
      `CHK("format", {v[7:5], v[1:0] < 2'h2, v[1:0] == DCR_WIDTH_NIBBLE, v[1:0] == DCR_WIDTH_INVALID}, format)
      `CHK("data_ordered", v[5] ? sw : data_in, data_ordered)
    end
    wr(DCR_ADDR_IRQEN, 8'h80);
    pll_lock_in <= 1'b1;
    repeat (10) @(posedge clock);
    `CHK("irq", 1'b0, irq)
    rd(DCR_ADDR_FLAGS, 8'h40);
    wr(DCR_ADDR_IRQEN, 8'h40);
    wait_irq(1'b1);
    wr(DCR_ADDR_FLAGS, 8'h40);
    wait_irq(1'b0);
    pll_lock_in <= 1'b0;
    rd(DCR_ADDR_FLAGS, 8'h80);
    wr(DCR_ADDR_IRQEN, 8'hFF);
    rd(DCR_ADDR_IRQEN, DCR_EV_MASK);
    sync_lock_in <= 1'b1;
    rd(DCR_ADDR_FLAGS, 8'h90);
    wr(DCR_ADDR_FLAGS, 8'hF0);
    sync_lock_in <= 1'b0;
    rd(DCR_ADDR_FLAGS, 8'h20);
    wait_irq(1'b1);
    wr(DCR_ADDR_FLAGS, 8'h20);
    wait_irq(1'b0);
    transmit_gate_pin <= 1'b0;
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK("power_down", 5'h00, power_down)
    `CHK("format", 6'h04, format)
    for (int a = 2; a < 5; a++) rd(7'(a), 8'h00);
    rd(7'h10, 8'h00);
    print_verdict();
  end
endmodule : testbench
